// ---- verilog/csb_consts.vh ----
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH
// register offsets
`define CSB_ADDR_IRQ_STATUS   8'h01
`define CSB_ADDR_SECT_STATUS  8'h0c
`define CSB_ADDR_SECT_STATUS1 8'h0d
`define CSB_ADDR_SECT_STATUS2 8'h0e
`define CSB_ADDR_SECT_STATUS3 8'h0f
`define CSB_ADDR_DEC_PTR_LO   8'h28
`define CSB_ADDR_DEC_PTR_HI   8'h29
`define CSB_ADDR_BUF_MODE     8'h5c
`define CSB_ADDR_CHK_STATUS   8'h80
`define CSB_ADDR_MASK0        8'h8c
`define CSB_ADDR_MASK1        8'h8d
`define CSB_ADDR_MASK2        8'h8e
`define CSB_ADDR_MASK3        8'h8f
`define CSB_ADDR_INDEP_CTRL   8'h9a
`define CSB_ADDR_BUF_LIMIT    8'h9b
`define CSB_ADDR_CACHE_CTRL   8'h9c
`define CSB_ADDR_CREDIT       8'h9d
`define CSB_ADDR_SKIP         8'h9e
`define CSB_ADDR_REMAIN       8'h9f
`define CSB_ADDR_BUF_PTR_LO   8'ha0
`define CSB_ADDR_BUF_PTR_HI   8'ha1
`define CSB_ADDR_BLK_COUNT    8'ha2
`define CSB_ADDR_ROUND        8'ha3
`define CSB_ADDR_IRQ_CLEAR    8'ha4
// field positions
`define CSB_BIT_RED_EN        0
`define CSB_BIT_IC_EN         7
`define CSB_BIT_CREDIT_INC    5
`define CSB_BIT_AUTO_CACHE    6
`define CSB_BIT_STA_ERR       6
`define CSB_BIT_LAST_BLK      3
`define CSB_BIT_HDR_ERR       0
`define CSB_BIT_SECT_RDY      5
`define CSB_BIT_XFER_END      6
// reset values and pointer width
`define CSB_RST_BLK_COUNT     8'h10
`define CSB_PTR_W             12
`endif

// ---- verilog/csb_wrap_ptr.v ----
`timescale 1ns/1ps
module csb_wrap_ptr #(
	parameter W = 12
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         inc_i,
	input  wire         load_i,
	input  wire [W-1:0] load_val_i,
	input  wire [W-1:0] limit_i,
	output reg  [W-1:0] ptr_o
);
	wire [W-1:0] next_ptr;
	assign next_ptr = (ptr_o + 1'b1 >= limit_i) ? {W{1'b0}} : ptr_o + 1'b1;
	always @(posedge clk_i)
	begin
		if (rst_i)
			ptr_o <= {W{1'b0}};
		else if (load_i)
			ptr_o <= load_val_i;
		else if (inc_i)
			ptr_o <= next_ptr;
	end
endmodule

// ---- verilog/csb_sync2.v ----
`timescale 1ns/1ps
module csb_sync2 #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta <= {W{1'b0}};
			q_o  <= {W{1'b0}};
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// ---- verilog/csb_sector_buffer_manager.v ----
// Function
// - status collection on when any mask bit set
// - masked status error sets flag at check end
// - correction starts when over one sector pending
// - decode pointer advances on good check ends
// - buffer pointer advances on every sync while independent correction is on
// - erroneous sector retried up to round limit
// - reduction: ready flag only on error check ends or last block
// - first interrupt via last block flag
// - credit increments on clean check end
// - credit decrements per host block transfer
// - transfer end only on a block end while remaining count is one
// - header compare error flagged at check end
// - sector ready reported in interrupt status
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "csb_consts.vh"
module csb_sector_buffer_manager #(
	parameter PW = `CSB_PTR_W
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [7:0]  rdata_o,
	input  wire        check_end_i,
	input  wire [31:0] sector_status_i,
	input  wire [23:0] sector_header_i,
	input  wire [23:0] target_addr_i,
	input  wire        header_compare_en_i,
	input  wire        last_block_i,
	input  wire        sync_pin_i,
	input  wire        block_xfer_end_i,
	output reg         correction_start_o,
	output reg  [PW-1:0] correct_block_o,
	output reg         sector_ready_flag_o,
	output reg         transfer_end_flag_o
);
	reg  [31:0] status_error_mask;
	reg  [7:0]  buffer_mode_control;
	reg  [7:0]  independent_correction_ctrl;
	reg  [7:0]  buffering_limit;
	reg  [7:0]  cache_control;
	reg  [7:0]  transfer_credit_count;
	reg  [7:0]  skip_count;
	reg  [7:0]  remaining_transfer_count;
	reg  [7:0]  block_count;
	reg  [31:0] sect_status;
	reg         status_error_flag;
	reg         header_compare_error_flag;
	reg         last_block_flag;
	reg  [3:0]  round_count;
	reg         sync_d;

	wire        sync_s;
	wire        sync_pulse;
	wire [PW-1:0] decode_block_pointer;
	wire [PW-1:0] buffer_block_pointer;
	wire        mode_ic;
	wire        collect_en;
	wire        sta_err_now;
	wire        hdr_err_now;
	wire        sect_bad;
	wire        dec_inc;
	wire        retry_ok;
	wire [PW-1:0] pending;
	wire [PW-1:0] limit;
	wire        dec_lo_wr;
	wire        dec_hi_wr;
	wire [PW-1:0] dec_load;
	wire        reduce;
	wire        credit_inc;
	wire        credit_dec;
	wire        clr_wr;
	wire        credit_wr;
	wire        round_step;
	wire        bad_retry;
	wire        dec_wr;
	wire        buf_inc;
	wire        pending_many;
	wire        ready_event;
	wire        end_event;
	wire        clr_ready;
	wire        clr_end;
	wire        clr_last;
	wire [7:0]  irq_status;
	wire [7:0]  chk_status;
	reg  [7:0]  next_rdata;

	csb_sync2 #(.W(1)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (sync_pin_i),
		.q_o   (sync_s)
	);
	assign sync_pulse = sync_s & ~sync_d;

	assign mode_ic     = independent_correction_ctrl[`CSB_BIT_IC_EN];
	assign collect_en  = |status_error_mask;
	assign sta_err_now = collect_en & |(sector_status_i & status_error_mask);
	assign hdr_err_now = header_compare_en_i &
		(sector_header_i != target_addr_i);
	assign sect_bad    = sta_err_now | hdr_err_now;
	assign retry_ok    = round_count < cache_control[3:0];
	assign bad_retry   = sect_bad & retry_ok;
	assign round_step  = mode_ic & check_end_i;
	assign dec_inc     = round_step & ~bad_retry;
	assign limit       = {{(PW-8){1'b0}}, block_count};
	assign pending     = (buffer_block_pointer >= decode_block_pointer) ?
		buffer_block_pointer - decode_block_pointer :
		buffer_block_pointer + limit - decode_block_pointer;
	assign dec_lo_wr   = wr_i & (addr_i == `CSB_ADDR_DEC_PTR_LO);
	assign dec_hi_wr   = wr_i & (addr_i == `CSB_ADDR_DEC_PTR_HI);
	assign dec_load    = dec_lo_wr ?
		{decode_block_pointer[PW-1:8], wdata_i} :
		{wdata_i[PW-9:0], decode_block_pointer[7:0]};
	assign reduce      = buffer_mode_control[`CSB_BIT_RED_EN];
	assign credit_inc  = cache_control[`CSB_BIT_CREDIT_INC] & check_end_i &
		~sect_bad;
	assign credit_dec  = cache_control[`CSB_BIT_AUTO_CACHE] &
		block_xfer_end_i;
	assign clr_wr      = wr_i & (addr_i == `CSB_ADDR_IRQ_CLEAR);
	assign clr_ready   = clr_wr & wdata_i[`CSB_BIT_SECT_RDY];
	assign clr_end     = clr_wr & wdata_i[`CSB_BIT_XFER_END];
	assign clr_last    = clr_wr & wdata_i[`CSB_BIT_LAST_BLK];
	assign credit_wr   = wr_i & (addr_i == `CSB_ADDR_CREDIT);
	assign dec_wr      = dec_lo_wr | dec_hi_wr;
	assign buf_inc     = mode_ic & sync_pulse;
	assign pending_many = pending > {{(PW-1){1'b0}}, 1'b1};
	assign ready_event = reduce ? (check_end_i & sect_bad) | last_block_i :
		check_end_i | last_block_i;
	assign end_event   = block_xfer_end_i &
		(remaining_transfer_count == 8'h01);
	assign irq_status  = {1'b0, transfer_end_flag_o, sector_ready_flag_o,
		5'h00};
	assign chk_status  = {1'b0, status_error_flag, 2'b00, last_block_flag,
		2'b00, header_compare_error_flag};

	csb_wrap_ptr #(.W(PW)) u_dec_ptr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.inc_i      (dec_inc),
		.load_i     (dec_wr),
		.load_val_i (dec_load),
		.limit_i    (limit),
		.ptr_o      (decode_block_pointer)
	);

	csb_wrap_ptr #(.W(PW)) u_buf_ptr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.inc_i      (buf_inc),
		.load_i     (1'b0),
		.load_val_i ({PW{1'b0}}),
		.limit_i    (limit),
		.ptr_o      (buffer_block_pointer)
	);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			buffer_mode_control         <= 8'h00;
			independent_correction_ctrl <= 8'h00;
			buffering_limit             <= 8'h00;
			cache_control               <= 8'h00;
			skip_count                  <= 8'h00;
		end
		else if (wr_i)
		begin
			case (addr_i)
			`CSB_ADDR_BUF_MODE:    buffer_mode_control <= wdata_i;
			`CSB_ADDR_INDEP_CTRL:  independent_correction_ctrl <= wdata_i;
			`CSB_ADDR_BUF_LIMIT:   buffering_limit <= wdata_i;
			`CSB_ADDR_CACHE_CTRL:  cache_control <= wdata_i;
			`CSB_ADDR_SKIP:        skip_count <= wdata_i;
			default:               ;
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			status_error_mask <= 32'h0000_0000;
		else if (wr_i)
		begin
			case (addr_i)
			`CSB_ADDR_MASK0: status_error_mask[7:0]   <= wdata_i;
			`CSB_ADDR_MASK1: status_error_mask[15:8]  <= wdata_i;
			`CSB_ADDR_MASK2: status_error_mask[23:16] <= wdata_i;
			`CSB_ADDR_MASK3: status_error_mask[31:24] <= wdata_i;
			default:         ;
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			block_count <= `CSB_RST_BLK_COUNT;
		else if (wr_i && addr_i == `CSB_ADDR_BLK_COUNT)
			block_count <= (wdata_i == 8'h00) ?
				8'h01 : wdata_i;
	end

	// other register writes no longer swallow a block end
	always @(posedge clk_i)
	begin
		if (rst_i)
			remaining_transfer_count <= 8'h00;
		else if (wr_i && addr_i == `CSB_ADDR_REMAIN)
			remaining_transfer_count <= wdata_i;
		else if (block_xfer_end_i && remaining_transfer_count != 8'h00)
			remaining_transfer_count <= remaining_transfer_count - 8'h01;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			transfer_credit_count <= 8'h00;
		else if (credit_wr)
			transfer_credit_count <= wdata_i;
		else if (credit_inc && !credit_dec)
			transfer_credit_count <= transfer_credit_count + 8'h01;
		else if (credit_dec && !credit_inc &&
			transfer_credit_count != 8'h00)
			transfer_credit_count <= transfer_credit_count - 8'h01;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			round_count <= 4'h0;
		else if (round_step)
			round_count <= bad_retry ?
				round_count + 4'h1 : 4'h0;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sect_status               <= 32'h0000_0000;
			status_error_flag         <= 1'b0;
			header_compare_error_flag <= 1'b0;
		end
		else if (check_end_i)
		begin
			sect_status               <= sector_status_i;
			status_error_flag         <= sta_err_now;
			header_compare_error_flag <= hdr_err_now;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			last_block_flag <= 1'b0;
		else if (last_block_i)
			last_block_flag <= 1'b1;
		else if (clr_last)
			last_block_flag <= 1'b0;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			sector_ready_flag_o <= 1'b0;
		else if (ready_event)
			sector_ready_flag_o <= 1'b1;
		else if (clr_ready)
			sector_ready_flag_o <= 1'b0;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			transfer_end_flag_o <= 1'b0;
		else if (end_event)
			transfer_end_flag_o <= 1'b1;
		else if (clr_end)
			transfer_end_flag_o <= 1'b0;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_d             <= 1'b0;
			correction_start_o <= 1'b0;
			correct_block_o    <= {PW{1'b0}};
		end
		else
		begin
			sync_d             <= sync_s;
			correction_start_o <= mode_ic & pending_many;
			correct_block_o    <= decode_block_pointer;
		end
	end

	always @*
	begin
		next_rdata = 8'h00;
		case (addr_i)
		`CSB_ADDR_IRQ_STATUS:  next_rdata = irq_status;
		`CSB_ADDR_SECT_STATUS: next_rdata = sect_status[7:0];
		`CSB_ADDR_SECT_STATUS1: next_rdata = sect_status[15:8];
		`CSB_ADDR_SECT_STATUS2: next_rdata = sect_status[23:16];
		`CSB_ADDR_SECT_STATUS3: next_rdata = sect_status[31:24];
		`CSB_ADDR_DEC_PTR_LO:  next_rdata = decode_block_pointer[7:0];
		`CSB_ADDR_DEC_PTR_HI:  next_rdata = {{(16-PW){1'b0}},
			decode_block_pointer[PW-1:8]};
		`CSB_ADDR_BUF_MODE:    next_rdata = buffer_mode_control;
		`CSB_ADDR_CHK_STATUS:  next_rdata = chk_status;
		`CSB_ADDR_INDEP_CTRL:  next_rdata = independent_correction_ctrl;
		`CSB_ADDR_BUF_LIMIT:   next_rdata = buffering_limit;
		`CSB_ADDR_CACHE_CTRL:  next_rdata = cache_control;
		`CSB_ADDR_CREDIT:      next_rdata = transfer_credit_count;
		`CSB_ADDR_SKIP:        next_rdata = skip_count;
		`CSB_ADDR_REMAIN:      next_rdata = remaining_transfer_count;
		`CSB_ADDR_BUF_PTR_LO:  next_rdata = buffer_block_pointer[7:0];
		`CSB_ADDR_BUF_PTR_HI:  next_rdata = {{(16-PW){1'b0}},
			buffer_block_pointer[PW-1:8]};
		`CSB_ADDR_BLK_COUNT:   next_rdata = block_count;
		`CSB_ADDR_ROUND:       next_rdata = {4'h0, round_count};
		default:               next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= 8'h00;
	end
endmodule

// ---- tb/csb_sbm_assertions.sv ----
`timescale 1ns/1ps
module csb_sbm_assertions #(
	parameter PW = 12
) (
	input wire          clk_i,
	input wire          rst_i,
	input wire [7:0]    addr_i,
	input wire [7:0]    wdata_i,
	input wire          wr_i,
	input wire          rd_i,
	input wire [7:0]    rdata_o,
	input wire          check_end_i,
	input wire          last_block_i,
	input wire          block_xfer_end_i,
	input wire          correction_start_o,
	input wire [PW-1:0] correct_block_o,
	input wire          sector_ready_flag_o,
	input wire          transfer_end_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire clr = wr_i && addr_i == 8'ha4;
	a_reset_clear: assert property ($fell(rst_i) |->
		!sector_ready_flag_o && !transfer_end_flag_o && correct_block_o == 0)
		else $error("outputs not clear after reset");
	a_last_ready: assert property (last_block_i |=> sector_ready_flag_o)
		else $error("last block did not set ready");
	a_ready_hold: assert property (sector_ready_flag_o &&
		!(clr && wdata_i[5]) |=> sector_ready_flag_o)
		else $error("ready flag dropped");
	a_end_hold: assert property (transfer_end_flag_o &&
		!(clr && wdata_i[6]) |=> transfer_end_flag_o)
		else $error("transfer end dropped");
	a_ready_cause: assert property ($rose(sector_ready_flag_o) |->
		$past(check_end_i || last_block_i))
		else $error("ready flag without event");
	a_end_cause: assert property ($rose(transfer_end_flag_o) |->
		$past(block_xfer_end_i))
		else $error("transfer end without block");
	a_ptr_cause: assert property (!$stable(correct_block_o) |->
		$past(check_end_i || wr_i) || $past(check_end_i || wr_i, 2))
		else $error("decode pointer moved alone");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read");
	cover property (last_block_i);
	cover property ($rose(transfer_end_flag_o));
	cover property ($rose(correction_start_o));
endmodule
bind csb_sector_buffer_manager csb_sbm_assertions #(.PW(PW)) chk_u (
	.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.check_end_i, .last_block_i, .block_xfer_end_i, .correction_start_o,
	.correct_block_o, .sector_ready_flag_o, .transfer_end_flag_o);

// ---- tb/csb_host_model.sv ----
`timescale 1ns/1ps
module csb_host_model (
	input  wire clk_i,
	input  wire req_i,
	input  wire slow_i,
	output reg  done_o
);
	reg [2:0] n;
	initial
	begin
		done_o = 1'b0;
		n = 3'h0;
	end
	// one data-in block, answered promptly or late
	always @(posedge clk_i)
	begin
		done_o <= n == 3'h1;
		if (req_i)
			n <= slow_i ? 3'h5 : 3'h1;
		else if (n != 3'h0)
			n <= n - 3'h1;
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	reg         clk_i, rst_i, wr_i, rd_i, ce_r, lb_r, sy_r, req, slow;
	reg         hen, rd_d;
	reg  [7:0]  addr_i, wdata_i;
	reg  [31:0] st;
	reg  [23:0] hdr, tgt;
	wire [7:0]  rdata_o;
	wire [11:0] cblk;
	wire        xe, corr, rdy, tend;
	reg  [15:0] exp_q[$];
	reg  [15:0] e;
	integer     bad_count, n_checks, cyc;
	csb_sector_buffer_manager dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .check_end_i(ce_r), .sector_status_i(st),
		.sector_header_i(hdr), .target_addr_i(tgt),
		.header_compare_en_i(hen), .last_block_i(lb_r), .sync_pin_i(sy_r),
		.block_xfer_end_i(xe), .correction_start_o(corr),
		.correct_block_o(cblk), .sector_ready_flag_o(rdy),
		.transfer_end_flag_o(tend));
	csb_host_model host_u (.clk_i(clk_i), .req_i(req), .slow_i(slow),
		.done_o(xe));
	initial
	begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end
	task end_of_test;
	begin
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task chk(input string nm, input [7:0] w, input [7:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== w)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %0s exp %h got %h", nm, w, g);
		end
	end
	endtask
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (rd_d)
		begin
			e = exp_q.pop_front();
			chk("rdata", e[7:0], rdata_o & e[15:8]);
		end
		rd_d <= rd_i;
		if (cyc > 3000)
		begin
			bad_count = bad_count + 1;
			end_of_test;
		end
	end
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	end
	endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] x);
	begin
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		exp_q.push_back({m, x & m});
		@(posedge clk_i);
		rd_i <= 0;
	end
	endtask
	task ce(input [31:0] s, input h);
	begin
		@(posedge clk_i);
		st <= s;
		hen <= h;
		hdr <= tgt ^ {23'h0, h};
		ce_r <= 1;
		@(posedge clk_i);
		ce_r <= 0;
	end
	endtask
	task pin(input w);
	begin
		@(posedge clk_i);
		if (w)
			lb_r <= 1;
		else
			sy_r <= 1;
		repeat (3) @(posedge clk_i);
		lb_r <= 0;
		sy_r <= 0;
		repeat (3) @(posedge clk_i);
	end
	endtask
	task xf(input s);
	begin
		@(posedge clk_i);
		slow <= s;
		req <= 1;
		@(posedge clk_i);
		req <= 0;
		repeat (8) @(posedge clk_i);
	end
	endtask
	initial
	begin
		{rst_i, wr_i, rd_i, ce_r, lb_r, sy_r, req, slow, hen, rd_d} = 10'h200;
		{addr_i, wdata_i, st, hdr} = 0;
		bad_count = 0;
		n_checks = 0;
		cyc = 0;
		void'($urandom(13));
		tgt = $urandom;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rd(8'h9d, 8'hff, 8'h00);
		wr(8'h9c, 8'h20);
		repeat (3) ce($urandom, 0);
		rd(8'h9d, 8'hff, 8'h03);
		rd(8'h01, 8'h20, 8'h20);
		wr(8'h8c, 8'h01);
		ce(32'h1, 0);
		rd(8'h80, 8'h40, 8'h40);
		wr(8'h8c, 8'h00);
		ce(32'h0, 1);
		rd(8'h80, 8'h41, 8'h01);
		rd(8'h9d, 8'hff, 8'h03);
		wr(8'h9c, 8'h40);
		wr(8'h9f, 8'h02);
		wr(8'ha4, 8'hff);
		xf(0);
		rd(8'h01, 8'h40, 8'h00);
		xf(1);
		rd(8'h01, 8'h40, 8'h40);
		chk("tend", 8'h01, {7'h0, tend});
		rd(8'h9d, 8'hff, 8'h01);
		wr(8'h9d, 8'h00);
		rd(8'h9d, 8'hff, 8'h00);
		wr(8'h5c, 8'h01);
		wr(8'ha4, 8'hff);
		ce($urandom, 0);
		rd(8'h01, 8'h20, 8'h00);
		pin(1);
		rd(8'h01, 8'h20, 8'h20);
		rd(8'h80, 8'h08, 8'h08);
		chk("rdy", 8'h01, {7'h0, rdy});
		rst_i <= 1;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		wr(8'h9a, 8'hb0);
		wr(8'h9b, 8'h08);
		rd(8'h9b, 8'hff, 8'h08);
		repeat (3) pin(0);
		rd(8'ha0, 8'hff, 8'h03);
		chk("corr", 8'h01, {7'h0, corr});
		repeat (2) ce(32'h0, 0);
		wr(8'h8c, 8'h01);
		wr(8'h9c, 8'h0f);
		ce(32'h1, 0);
		rd(8'h28, 8'hff, 8'h02);
		chk("blk", 8'h02, cblk[7:0]);
		chk("corr", 8'h00, {7'h0, corr});
		rd(8'ha3, 8'h0f, 8'h01);
		wr(8'h9c, 8'h01);
		ce(32'h1, 0);
		rd(8'h28, 8'hff, 8'h03);
		rd(8'ha3, 8'h0f, 8'h00);
		wr(8'ha2, 8'h04);
		ce(32'h0, 0);
		rd(8'h28, 8'hff, 8'h00);
		repeat (3) @(posedge clk_i);
		end_of_test;
	end
endmodule
